/* remote_rx_params.svh */
// constants for the remote signal preprocessor
// Operation
// R01: software sets the port latch to one before using the pin as input
// R02: without the preprocessor the pin stays an ordinary port bit
// R03: plain interrupt use needs a source code other than eleven
// R04: counter clock is system clock over 2^6, 2^8, 2^10 or 2^12
// R05: polarity bit zero keeps the signal, one inverts it
// R06: source code picks rising, falling, both edges or eight-bit receive end
// R07: filter code zero bypasses, else rejects pulses up to 2^k*7-1 clocks
// R08: filtered pulses of at least 2^k*7 clocks always pass
// R09: threshold nibble is compared with the counter's upper nibble
// R10: software loads the threshold before choosing the source
// R11: run bit zero stops and clears the counter, one starts it
// R12: enable bit switches the whole preprocessor off or on; here it holds the counter clear and blocks capture, overflow and receive, pin edges still interrupt
// R13: measure mode picks the interval, ignored for both-edge source
// R14: both-edge source measures low and high widths separately
// R15: on completion capture counter, clear it, raise interrupt, keep counting
// R16: counter at FF raises interrupt, sets overflow, clears and stops
// R17: writing run one also clears the overflow flag
// R18: receive end decides bits by threshold, shifts, counts, interrupts at eight
// R19: input pin is synchronised before filtering and edge detection
// R20: status shows bit count, overflow, compare result, filtered level
`ifndef REMOTE_RX_PARAMS_SVH
`define REMOTE_RX_PARAMS_SVH
`define RRX_CTL1_OFS 12'hFE8
`define RRX_CTL2_OFS 12'hFE9
`define RRX_CAP_OFS 12'hFEA
`define RRX_BUF_OFS 12'hFEB
`define RRX_STAT_OFS 12'hFEC
`define RRX_PORT_OFS 12'hFED
`define RRX_CTL1_RST 8'h00
`define RRX_CTL2_RST 8'h00
`define RRX_PORT_RST 8'h01
`define RRX_NF_K1 2
`define RRX_NF_K2 5
`define RRX_NF_K3 6
`define RRX_NF_K4 7
`define RRX_NF_K5 8
`define RRX_NF_K6 10
`define RRX_NF_K7 11
`define RRX_NF_MUL 7
`define RRX_DIV_BASE 6
`define RRX_CNT_MAX 8'hFF
`define RRX_RX_BITS 4'h8
`endif

/* remote_rx_pkg.sv */
// types for the remote signal preprocessor
package remote_rx_pkg;
   typedef enum logic [1:0] {
      SRC_RISE = 2'b00,
      SRC_FALL = 2'b01,
      SRC_BOTH = 2'b10,
      SRC_RX8 = 2'b11
   } irq_src_t;
   typedef struct packed {
      logic [1:0] counter_clock_select;
      logic signal_polarity;
      irq_src_t irq_source_select;
      logic [2:0] noise_filter_select;
   } ctl_one_t;
   typedef struct packed {
      logic [3:0] bit_threshold;
      logic counter_run;
      logic preprocessor_enable;
      logic [1:0] measure_mode;
   } ctl_two_t;
   typedef enum logic [2:0] {
      ST_STOP = 3'b001,
      ST_RUN = 3'b010,
      ST_OVF = 3'b100
   } cnt_state_t;
endpackage

/* remote_signal_preprocessor.sv */
// remote signal preprocessor with capture counter and bit receiver
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "remote_rx_params.svh"
module remote_signal_preprocessor
   import remote_rx_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // register port
   input wire logic [11:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rd_data_o,
   // shared port pin
   input wire logic shared_port_pin_i,
   output logic shared_port_pin_o,
   output logic shared_port_pin_oe_n_o,
   // interrupt request
   output logic external_irq_three_o
);
   ctl_one_t ctl1_r;
   ctl_two_t ctl2_r;
   cnt_state_t st_r;
   cnt_state_t st_nxt;
   logic [7:0] port_r;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic [7:0] cap_r;
   logic [7:0] buf_r;
   logic [3:0] bits_r;
   logic ovf_r;
   logic [11:0] pre_r;
   logic sync1_r;
   logic sync2_r;
   logic filt_r;
   logic [13:0] flt_cnt_r;
   logic sig_d_r;
   logic irq_r;
   logic [7:0] rd_r;

   // decode
   wire wr1 = wr_i && addr_i == `RRX_CTL1_OFS;
   wire wr2 = wr_i && addr_i == `RRX_CTL2_OFS;
   wire wrp = wr_i && addr_i == `RRX_PORT_OFS;
   ctl_two_t wctl2;
   assign wctl2 = ctl_two_t'(wr_data_i);
   wire start_wr = wr2 && wctl2.counter_run;
   wire stop_wr = wr2 && !wctl2.counter_run;

   // prescaler tick, mask grows two bits per select step
   wire [3:0] div_sh = 4'(`RRX_DIV_BASE) +
                       {1'b0, ctl1_r.counter_clock_select, 1'b0};
   wire [11:0] div_mask = 12'((13'h1 << div_sh) - 13'h1);
   wire tick = (pre_r & div_mask) == div_mask; // R04

   // noise filter length, count of clocks a new level must hold
   function automatic logic [13:0] flt_len_f(input logic [2:0] c);
      logic [4:0] k;
      k = 5'd0;
      case (c)
         3'd1: k = 5'(`RRX_NF_K1);
         3'd2: k = 5'(`RRX_NF_K2);
         3'd3: k = 5'(`RRX_NF_K3);
         3'd4: k = 5'(`RRX_NF_K4);
         3'd5: k = 5'(`RRX_NF_K5);
         3'd6: k = 5'(`RRX_NF_K6);
         3'd7: k = 5'(`RRX_NF_K7);
         default: k = 5'd0;
      endcase
      flt_len_f = 14'(`RRX_NF_MUL << k);
   endfunction
   wire [13:0] flt_len = flt_len_f(ctl1_r.noise_filter_select);
   wire nf_off = ctl1_r.noise_filter_select == 3'd0;
   wire flt_hit = flt_cnt_r == flt_len - 14'd1; // R07 R08

   // edges after polarity
   wire sig = filt_r ^ ctl1_r.signal_polarity; // R05
   wire rise = sig && !sig_d_r;
   wire fall = !sig && sig_d_r;
   // receive end decides one bit per rising edge only
   wire src_edge = (ctl1_r.irq_source_select == SRC_RISE) ? rise :
                   (ctl1_r.irq_source_select == SRC_FALL) ? fall :
                   (ctl1_r.irq_source_select == SRC_BOTH) ? (rise || fall) :
                   rise; // R06 R14 R18
   wire rx_mode = ctl1_r.irq_source_select == SRC_RX8;
   // width mode: opposite edge restarts the count without capture
   wire width_md = ctl2_r.measure_mode[0] &&
                   ctl1_r.irq_source_select != SRC_BOTH; // R13
   wire opp_edge = width_md &&
                   ((ctl1_r.irq_source_select == SRC_FALL) ? rise : fall);
   wire running = ctl2_r.preprocessor_enable && st_r == ST_RUN; // R12
   wire done = running && src_edge; // R15
   wire restart = running && opp_edge && !src_edge;
   wire ovf_evt = running && !done && !restart && tick &&
                  cnt_r == `RRX_CNT_MAX; // R16
   wire cmp = cnt_r[7:4] >= ctl2_r.bit_threshold; // R09
   wire rx_shift = done && rx_mode; // R18
   wire [3:0] bits_nxt = (bits_r == `RRX_RX_BITS) ? 4'h1 : bits_r + 4'h1;
   wire rx_full = rx_shift && bits_nxt == `RRX_RX_BITS;
   // pin edges still interrupt with the preprocessor off
   wire irq_evt = (src_edge && !rx_mode) || rx_full || ovf_evt; // R03 R06

   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      // run writes act while disabled, so enable and run land together
      if (stop_wr)
      begin
         st_nxt = ST_STOP; // R11
         cnt_nxt = 8'h00;
      end
      else if (start_wr)
      begin
         st_nxt = ST_RUN; // R11
         cnt_nxt = 8'h00;
      end
      else if (!ctl2_r.preprocessor_enable)
      begin
         cnt_nxt = 8'h00; // R12
      end
      else if (done || restart)
      begin
         cnt_nxt = 8'h00; // R15
      end
      else if (ovf_evt)
      begin
         st_nxt = ST_OVF; // R16
         cnt_nxt = 8'h00;
      end
      else if (running && tick)
      begin
         cnt_nxt = cnt_r + 8'h01;
      end
      case (st_r)
         ST_STOP, ST_RUN, ST_OVF: ;
         default: st_nxt = ST_STOP;
      endcase
   end

   // read mux
   wire [7:0] stat = {bits_r, 1'b0, ovf_r, cmp, filt_r}; // R20
   wire [7:0] rd_mux =
      (addr_i == `RRX_CTL1_OFS) ? ctl1_r :
      (addr_i == `RRX_CTL2_OFS) ? ctl2_r :
      (addr_i == `RRX_CAP_OFS) ? cap_r :
      (addr_i == `RRX_BUF_OFS) ? buf_r :
      (addr_i == `RRX_STAT_OFS) ? stat :
      (addr_i == `RRX_PORT_OFS) ? {6'h00, sync2_r, port_r[0]} : 8'h00;

   // registers
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctl1_r <= ctl_one_t'(`RRX_CTL1_RST);
         ctl2_r <= ctl_two_t'(`RRX_CTL2_RST);
         port_r <= `RRX_PORT_RST;
         rd_r <= 8'h00;
      end
      else
      begin
         if (wr1)
            ctl1_r <= ctl_one_t'(wr_data_i);
         if (wr2)
            ctl2_r <= wctl2;
         if (wrp)
            port_r <= {7'h00, wr_data_i[0]}; // R02
         rd_r <= rd_i ? rd_mux : 8'h00;
      end
   end

   // synchroniser and noise filter
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         // idle high like the pin, so no false edge follows reset
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         filt_r <= 1'b1;
         flt_cnt_r <= 14'h0000;
         sig_d_r <= 1'b1;
         pre_r <= 12'h000;
      end
      else
      begin
         sync1_r <= shared_port_pin_i; // R19
         sync2_r <= sync1_r;
         pre_r <= pre_r + 12'h001;
         sig_d_r <= sig;
         if (nf_off || sync2_r == filt_r)
         begin
            flt_cnt_r <= 14'h0000;
            filt_r <= nf_off ? sync2_r : filt_r;
         end
         else if (flt_hit)
         begin
            flt_cnt_r <= 14'h0000;
            filt_r <= sync2_r; // R07 R08
         end
         else
            flt_cnt_r <= flt_cnt_r + 14'h0001;
      end
   end

   // counter, capture, receiver
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_r <= ST_STOP;
         cnt_r <= 8'h00;
         cap_r <= 8'h00;
         buf_r <= 8'h00;
         bits_r <= 4'h0;
         ovf_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         irq_r <= irq_evt; // R15 R16 R18
         if (done)
            cap_r <= cnt_r; // R15
         if (rx_shift)
         begin
            buf_r <= {buf_r[6:0], cmp}; // R18
            bits_r <= bits_nxt;
         end
         // a fresh overflow wins over the clear by a start write
         if (ovf_evt)
            ovf_r <= 1'b1; // R16
         else if (start_wr)
            ovf_r <= 1'b0; // R17
      end
   end

   assign rd_data_o = rd_r;
   assign external_irq_three_o = irq_r;
   // open drain: latch low drives the pin low
   assign shared_port_pin_o = port_r[0]; // R01 R02
   assign shared_port_pin_oe_n_o = port_r[0];

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   // a control write in the same cycle takes priority
   sequence s_ovf;
      ovf_evt && !wr2;
   endsequence
   sequence s_ovf_after;
      ovf_r && cnt_r == 8'h00 && st_r == ST_OVF && irq_r;
   endsequence
   overflow_stop_a: assert property (s_ovf |=> s_ovf_after) // R16
      else $error("overflow did not stop counter");
   sequence s_done;
      done && !stop_wr && !start_wr;
   endsequence
   capture_on_done_a: assert property ( // R15
      s_done |=> cap_r == $past(cnt_r) && cnt_r == 8'h00 &&
      irq_r == (!$past(rx_mode) || $past(rx_full)))
      else $error("capture at completion wrong");
   stop_clears_a: assert property ( // R11
      stop_wr |=> cnt_r == 8'h00 && st_r == ST_STOP)
      else $error("stop write did not clear counter");
   start_clears_ovf_a: assert property ( // R17
      start_wr && !ovf_evt |=> !ovf_r && st_r == ST_RUN)
      else $error("start write did not clear overflow");
   disabled_idle_a: assert property ( // R12
      !ctl2_r.preprocessor_enable |=> cnt_r == 8'h00 && !$rose(ovf_r))
      else $error("counter active while disabled");
   rx_bit_decide_a: assert property ( // R18
      rx_shift |=> buf_r[0] == $past(cmp) &&
      buf_r[7:1] == $past(buf_r[6:0]))
      else $error("received bit not shifted in");
   prescale_tick_a: assert property ( // R04
      tick |-> pre_r[5:0] == 6'h3F && !$past(tick))
      else $error("counter clock tick misplaced");
   filter_hold_a: assert property ( // R07
      !nf_off && !$past(nf_off) && $changed(filt_r) |->
      $past(flt_cnt_r) == $past(flt_len) - 14'd1)
      else $error("filter passed a short pulse");
   sync_path_a: assert property ( // R19
      nf_off |=> filt_r == $past(sync2_r))
      else $error("bypassed filter not following input");
   sequence s_edge_req;
      src_edge && !rx_mode;
   endsequence
   // plain edge interrupts keep working with the counter off
   edge_irq_a: assert property (s_edge_req |=> irq_r) // R06
      else $error("pin edge did not request interrupt");
   sequence s_rx_eighth;
      rx_shift && bits_nxt == `RRX_RX_BITS;
   endsequence
   rx_end_irq_a: assert property ( // R18
      s_rx_eighth |=> irq_r && bits_r == `RRX_RX_BITS)
      else $error("eighth bit did not request interrupt");
   sequence s_rx_bit;
      rx_shift && bits_nxt != `RRX_RX_BITS;
   endsequence
   rx_quiet_a: assert property (s_rx_bit |=> !irq_r) // R18
      else $error("interrupt before eighth bit");
endmodule
`default_nettype wire

/* ir_receiver_model.sv */
// infrared receiver output model driving the shared pin
`timescale 1ns/1ns
`default_nettype none
module ir_receiver_model (
   // clock
   input wire logic sys_clk_i,
   // demodulated signal, idle high like a real receiver
   output var logic level_o
);
   initial level_o = 1'b1;
   // level changes just after an edge and holds for whole cycles
   task automatic drive(input logic lvl, input int cycles);
      @(posedge sys_clk_i);
      level_o <= lvl;
      repeat (cycles - 1) @(posedge sys_clk_i);
   endtask
endmodule
`default_nettype wire

/* tb.sv */
// testbench for the remote signal preprocessor
`timescale 1ns/1ns
`default_nettype none
`include "remote_rx_params.svh"
module tb;
   logic sys_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [7:0] wr_data_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rd_data_o;
   logic pin_o;
   logic pin_oe_n;
   logic irq;
   logic ir_level;
   logic pin_w;
   int fails = 0;
   int num_checks = 0;
   int irqs = 0;
   logic [7:0] mode_tab [6] = '{8'h00, 8'h08, 8'h10, 8'h20, 8'h28, 8'h30};
   int lo_tab [6] = '{0, 1, 1, 1, 0, 1};
   int hi_tab [6] = '{1, 0, 1, 0, 1, 1};
   logic [7:0] rx_pat = 8'hB2;
   // the port drives the wire only low, the receiver holds it high
   assign pin_w = ir_level & (pin_oe_n | pin_o);
   initial
   begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i)
      if (irq === 1'b1)
         irqs <= irqs + 1;
   remote_signal_preprocessor DUT (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .addr_i(addr_i),
      .wr_data_i(wr_data_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rd_data_o(rd_data_o),
      .shared_port_pin_i(pin_w),
      .shared_port_pin_o(pin_o),
      .shared_port_pin_oe_n_o(pin_oe_n),
      .external_irq_three_o(irq)
   );
   ir_receiver_model ir (
      .sys_clk_i(sys_clk_i),
      .level_o(ir_level)
   );
   task automatic stop_test;
      if (fails == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rdchk(input string what, input logic [11:0] a,
      input logic [7:0] exp);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(posedge sys_clk_i);
      chk(what, exp, rd_data_o);
   endtask
   // counts requests in the low phase, then in the high phase
   task automatic edges(input int lo, input int hi, input int e_lo,
      input int e_hi);
      int n;
      n = irqs;
      ir.drive(1'b0, lo);
      chk("irq low", 8'(e_lo), 8'(irqs - n));
      n = irqs;
      ir.drive(1'b1, hi);
      chk("irq high", 8'(e_hi), 8'(irqs - n));
   endtask
   task automatic capchk(input logic [7:0] lo, input logic [7:0] hi);
      @(posedge sys_clk_i);
      addr_i <= `RRX_CAP_OFS;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(posedge sys_clk_i);
      // prescaler phase is free running, so one tick either way
      chk("capture", 8'h01, {7'h00, rd_data_o >= lo && rd_data_o <= hi});
   endtask
   initial
   begin
      int n;
      repeat (16) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      rdchk("ctl1", `RRX_CTL1_OFS, 8'h00);
      rdchk("ctl2", `RRX_CTL2_OFS, 8'h00);
      rdchk("capture", `RRX_CAP_OFS, 8'h00);
      rdchk("buffer", `RRX_BUF_OFS, 8'h00);
      rdchk("unmapped", 12'h000, 8'h00);
      rdchk("port", `RRX_PORT_OFS, 8'h03);
      wr(`RRX_PORT_OFS, 8'h00);
      repeat (2) @(posedge sys_clk_i);
      rdchk("port low", `RRX_PORT_OFS, 8'h00);
      wr(`RRX_PORT_OFS, 8'h01);
      wr(`RRX_CAP_OFS, 8'hFF);
      rdchk("capture ro", `RRX_CAP_OFS, 8'h00);
      wr(`RRX_CTL1_OFS, 8'hA5);
      rdchk("ctl1 rw", `RRX_CTL1_OFS, 8'hA5);
      for (int i = 0; i < 6; i++)
      begin
         wr(`RRX_CTL1_OFS, mode_tab[i]);
         repeat (8) @(posedge sys_clk_i);
         edges(60, 100, lo_tab[i], hi_tab[i]);
      end
      wr(`RRX_CTL1_OFS, 8'h01);
      repeat (60) @(posedge sys_clk_i);
      edges(20, 100, 0, 0);
      edges(40, 100, 0, 1);
      wr(`RRX_CTL1_OFS, 8'h02);
      repeat (300) @(posedge sys_clk_i);
      edges(200, 300, 0, 0);
      edges(270, 300, 0, 1);
      wr(`RRX_CTL1_OFS, 8'h00);
      repeat (60) @(posedge sys_clk_i);
      wr(`RRX_CTL2_OFS, 8'h0C);
      edges(672, 100, 0, 1);
      capchk(8'h0A, 8'h0B);
      edges(572, 100, 0, 1);
      capchk(8'h0A, 8'h0B);
      // width mode: the falling edge restarts the count
      wr(`RRX_CTL2_OFS, 8'h0D);
      repeat (300) @(posedge sys_clk_i);
      edges(672, 100, 0, 1);
      capchk(8'h0A, 8'h0B);
      wr(`RRX_CTL1_OFS, 8'h40);
      wr(`RRX_CTL2_OFS, 8'h0C);
      edges(2700, 100, 0, 1);
      capchk(8'h0A, 8'h0B);
      wr(`RRX_CTL1_OFS, 8'h00);
      wr(`RRX_CTL2_OFS, 8'h0C);
      n = irqs;
      for (int i = 0; i < 17000 && irqs == n; i++)
         @(posedge sys_clk_i);
      if (irqs == n)
      begin
         fails++;
         stop_test;
      end
      rdchk("status ovf", `RRX_STAT_OFS, 8'h07);
      wr(`RRX_CTL2_OFS, 8'h0C);
      rdchk("status clr", `RRX_STAT_OFS, 8'h03);
      // stopped or disabled: edges interrupt, capture stays
      wr(`RRX_CTL2_OFS, 8'h04);
      edges(100, 100, 0, 1);
      capchk(8'h0A, 8'h0B);
      wr(`RRX_CTL2_OFS, 8'h08);
      edges(100, 100, 0, 1);
      capchk(8'h0A, 8'h0B);
      wr(`RRX_CTL2_OFS, 8'h2C);
      wr(`RRX_CTL1_OFS, 8'h18);
      for (int i = 7; i >= 0; i--)
         edges(rx_pat[i] ? 2900 : 900, 100, 0, int'(i == 0));
      rdchk("buffer", `RRX_BUF_OFS, rx_pat);
      rdchk("status rx", `RRX_STAT_OFS, 8'h81);
      stop_test;
   end
endmodule
`default_nettype wire
